/* eiwk_core_model.sv */
// Core-side partner: takes each vector request after a fixed lag.
// Assumes the request stands until the acknowledge is seen.
`timescale 1ns/10ps
module eiwk_core_model #(parameter int ACK_LAG = 2) (
    input  wire logic                clk,      // Clock
    input  wire eiwk_pkg::eiwk_vec_t vec_req,  // Request from block
    output logic                     vec_ack,  // Vector taken
    output logic [15:0]              last_vec, // Last vector fetched
    output int                       hits      // Vectors fetched
);
    int lag = 0;
    initial begin
        vec_ack = 1'b0;
        last_vec = 16'h0000;
        hits = 0;
    end
    // Ack held one cycle so the block sees it at the next edge
    always @(posedge clk) begin
        #1;
        lag = (vec_req.req && !vec_ack) ? lag + 1 : 0;
        vec_ack = (lag > ACK_LAG);
        if (vec_ack) begin
            last_vec = vec_req.vector;
            hits++;
        end
    end
endmodule

/* eiwk_pkg.sv */
// Package for the external interrupt and wake-up block.
// Assumes a single 200 MHz clock domain with synchronous active-high reset.
package eiwk_pkg;
    localparam logic [15:0] VEC_EXT_IRQ  = 16'h203C;
    localparam logic [15:0] VEC_NMI      = 16'h203E;
    localparam int          CLK_PERIOD_NS = 5;
    localparam int          STATE_TIME_NS = 125;
    localparam int          STATE_CYC     = (STATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  SYNC_RST      = 2'h0;

    typedef enum logic [1:0] {
        EIWK_RUN,
        EIWK_IDLE,
        EIWK_PDOWN
    } eiwk_mode_t;

    // Trigger configuration from the waveform protection register
    typedef struct packed {
        logic edge_mode;   // 1: edge triggered, 0: level sampled
        logic active_high; // 1: rising edge / high level
    } eiwk_trig_t;

    typedef struct packed {
        logic        req;
        logic [15:0] vector;
    } eiwk_vec_t;
endpackage

/* eiwk_top.sv */
// External interrupt / nonmaskable interrupt qualification and wake-up.
// Assumes the CPU core acknowledges a vector request and signals idle/powerdown entry.
`timescale 1ns/10ps
module eiwk_top (
    input  wire logic               CLK,          // 200 MHz clock
    input  wire logic               RST,          // Synchronous reset, high
    input  wire logic               EXT_IRQ_PIN,  // External interrupt pin
    input  wire logic               NMI_PIN,      // Nonmaskable interrupt pin
    input  wire eiwk_pkg::eiwk_trig_t TRIG_CFG,   // Trigger setup from protection register
    input  wire logic               EXT_IRQ_EN,   // External interrupt enabled
    input  wire logic               ENTER_IDLE,   // Pulse: idle entered
    input  wire logic               ENTER_PDOWN,  // Pulse: powerdown entered
    input  wire logic               VEC_ACK,      // Core fetched the vector
    output eiwk_pkg::eiwk_vec_t     VEC_REQ,      // Pending vector request
    output logic                    WAKE,         // Pulse: back to normal mode
    output eiwk_pkg::eiwk_mode_t    MODE          // Current power mode
);
    logic [1:0] ext_sync_r;
    logic [1:0] nmi_sync_r;
    logic       ext_prev_r;
    logic       nmi_prev_r;
    logic       ext_pend_r;
    logic       nmi_pend_r;
    logic       wake_r;
    eiwk_pkg::eiwk_mode_t mode_r;
    eiwk_pkg::eiwk_mode_t mode_nxt;
    eiwk_pkg::eiwk_vec_t  vec_r;
    eiwk_pkg::eiwk_vec_t  vec_nxt;

    // Fold the configured polarity so that 1 always means active
    function automatic logic act_lvl(input logic raw, input logic active_high);
        act_lvl = active_high ? raw : ~raw;
    endfunction

    wire ext_s     = ext_sync_r[1];
    wire nmi_s     = nmi_sync_r[1];
    wire ext_lvl   = act_lvl(ext_s, TRIG_CFG.active_high);
    wire ext_prv   = act_lvl(ext_prev_r, TRIG_CFG.active_high);
    wire ext_valid = TRIG_CFG.edge_mode ? (ext_lvl & ~ext_prv) : ext_lvl;
    wire nmi_rise  = nmi_s & ~nmi_prev_r;
    wire ext_take  = ext_valid & EXT_IRQ_EN;
    wire ext_wake  = (mode_r == eiwk_pkg::EIWK_IDLE) ? ext_take : ext_valid;
    wire nmi_wake  = (mode_r == eiwk_pkg::EIWK_IDLE) & nmi_rise;
    wire do_wake   = (mode_r != eiwk_pkg::EIWK_RUN) & (ext_wake | nmi_wake);

    // Modes
    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            eiwk_pkg::EIWK_RUN: begin
                if (ENTER_PDOWN) begin
                    mode_nxt = eiwk_pkg::EIWK_PDOWN;
                end else if (ENTER_IDLE) begin
                    mode_nxt = eiwk_pkg::EIWK_IDLE;
                end
            end
            default: begin
                if (do_wake) begin
                    mode_nxt = eiwk_pkg::EIWK_RUN;
                end
            end
        endcase
    end

    // Vector request: nonmaskable first, held until acknowledged
    always_comb begin
        vec_nxt = vec_r;
        if (VEC_ACK & vec_r.req) begin
            vec_nxt.req = 1'b0;
        end else if (!vec_r.req) begin
            if (nmi_pend_r) begin
                vec_nxt.req    = 1'b1;
                vec_nxt.vector = eiwk_pkg::VEC_NMI;
            end else if (ext_pend_r) begin
                vec_nxt.req    = 1'b1;
                vec_nxt.vector = eiwk_pkg::VEC_EXT_IRQ;
            end
        end
    end

    wire load_nmi = !vec_r.req & nmi_pend_r;
    wire load_ext = !vec_r.req & !nmi_pend_r & ext_pend_r;

    always_ff @(posedge CLK) begin
        if (RST) begin
            ext_sync_r <= eiwk_pkg::SYNC_RST;
            nmi_sync_r <= eiwk_pkg::SYNC_RST;
            ext_prev_r <= 1'b0;
            nmi_prev_r <= 1'b0;
            ext_pend_r <= 1'b0;
            nmi_pend_r <= 1'b0;
            wake_r     <= 1'b0;
            mode_r     <= eiwk_pkg::EIWK_RUN;
            vec_r      <= '0;
        end else begin
            ext_sync_r <= {ext_sync_r[0], EXT_IRQ_PIN};
            nmi_sync_r <= {nmi_sync_r[0], NMI_PIN};
            ext_prev_r <= ext_s;
            nmi_prev_r <= nmi_s;
            // A new event in the load cycle wins over the clear
            ext_pend_r <= ext_take | (ext_pend_r & ~load_ext);
            nmi_pend_r <= nmi_rise | (nmi_pend_r & ~load_nmi);
            wake_r     <= do_wake;
            mode_r     <= mode_nxt;
            vec_r      <= vec_nxt;
        end
    end

    assign VEC_REQ = vec_r;
    assign WAKE    = wake_r;
    assign MODE    = mode_r;

    // Wake-up from the low-power modes
    a_pdown_no_nmi: assert property (@(posedge CLK) disable iff (RST)
        (mode_r == eiwk_pkg::EIWK_PDOWN && !ext_valid)
        |=> mode_r == eiwk_pkg::EIWK_PDOWN)
        else $error("Powerdown left without external interrupt");

    a_idle_wake_ext: assert property (@(posedge CLK) disable iff (RST)
        (mode_r == eiwk_pkg::EIWK_IDLE && ext_take)
        |=> (mode_r == eiwk_pkg::EIWK_RUN && wake_r))
        else $error("Idle not left on enabled interrupt");

    a_idle_masked: assert property (@(posedge CLK) disable iff (RST)
        (mode_r == eiwk_pkg::EIWK_IDLE && !ext_take && !nmi_rise)
        |=> mode_r == eiwk_pkg::EIWK_IDLE)
        else $error("Idle left without an enabled request");

    a_pdown_wake_ext: assert property (@(posedge CLK) disable iff (RST)
        (mode_r == eiwk_pkg::EIWK_PDOWN && ext_valid)
        |=> mode_r == eiwk_pkg::EIWK_RUN)
        else $error("Powerdown not left on valid interrupt");

    a_idle_wake_nmi: assert property (@(posedge CLK) disable iff (RST)
        (mode_r == eiwk_pkg::EIWK_IDLE && nmi_rise)
        |=> mode_r == eiwk_pkg::EIWK_RUN)
        else $error("Idle not left on nonmaskable edge");

    a_pdown_nmi_queue: assert property (@(posedge CLK) disable iff (RST)
        (mode_r == eiwk_pkg::EIWK_PDOWN && nmi_rise)
        |=> nmi_pend_r)
        else $error("Nonmaskable edge in powerdown not queued");

    a_wake_pulse: assert property (@(posedge CLK) disable iff (RST)
        wake_r
        |=> !wake_r)
        else $error("Wake pulse longer than one cycle");

    a_wake_to_run: assert property (@(posedge CLK) disable iff (RST)
        wake_r
        |-> mode_r == eiwk_pkg::EIWK_RUN)
        else $error("Wake pulse outside normal mode");

    // Mode entry from the core
    a_idle_entry: assert property (@(posedge CLK) disable iff (RST)
        (mode_r == eiwk_pkg::EIWK_RUN && ENTER_IDLE && !ENTER_PDOWN)
        |=> mode_r == eiwk_pkg::EIWK_IDLE)
        else $error("Idle not entered");

    a_pdown_entry: assert property (@(posedge CLK) disable iff (RST)
        (mode_r == eiwk_pkg::EIWK_RUN && ENTER_PDOWN)
        |=> mode_r == eiwk_pkg::EIWK_PDOWN)
        else $error("Powerdown not entered");

    // Vectoring
    a_nmi_vector: assert property (@(posedge CLK) disable iff (RST)
        (nmi_rise && !vec_r.req && !nmi_pend_r && !ext_pend_r)
        |=> ##1 (vec_r.req && vec_r.vector == eiwk_pkg::VEC_NMI))
        else $error("Nonmaskable edge not vectored");

    a_nmi_pend_run: assert property (@(posedge CLK) disable iff (RST)
        (mode_r == eiwk_pkg::EIWK_RUN && nmi_rise)
        |=> nmi_pend_r)
        else $error("Nonmaskable edge not queued");

    a_ext_vector: assert property (@(posedge CLK) disable iff (RST)
        ($rose(vec_r.req) && !$past(nmi_pend_r))
        |-> vec_r.vector == eiwk_pkg::VEC_EXT_IRQ)
        else $error("Bad external vector");

    a_ext_pend: assert property (@(posedge CLK) disable iff (RST)
        ext_take
        |=> ext_pend_r)
        else $error("Enabled interrupt not queued");

    a_no_spurious: assert property (@(posedge CLK) disable iff (RST)
        (!ext_pend_r && !ext_take)
        |=> !ext_pend_r)
        else $error("External request queued without cause");

    a_ack_clears: assert property (@(posedge CLK) disable iff (RST)
        (vec_r.req && VEC_ACK)
        |=> !vec_r.req)
        else $error("Request not cleared by acknowledge");

    a_req_hold: assert property (@(posedge CLK) disable iff (RST)
        (vec_r.req && !VEC_ACK)
        |=> (vec_r.req && $stable(vec_r.vector)))
        else $error("Vector request dropped early");

    // Input qualification
    a_sync_delay: assert property (@(posedge CLK) disable iff (RST)
        $rose(NMI_PIN) ##1 NMI_PIN ##1 NMI_PIN
        |-> nmi_s)
        else $error("Pin not synchronised in two stages");

    a_edge_cfg: assert property (@(posedge CLK) disable iff (RST)
        (TRIG_CFG.edge_mode && ext_s == ext_prev_r)
        |-> !ext_valid)
        else $error("Edge mode fired without edge");

    // Main scenarios
    c_idle_nmi:  cover property (@(posedge CLK) mode_r == eiwk_pkg::EIWK_IDLE ##1 nmi_wake ##1 wake_r);
    c_pdown_ext: cover property (@(posedge CLK) mode_r == eiwk_pkg::EIWK_PDOWN ##1 ext_wake ##1 wake_r);
    c_ext_ack:   cover property (@(posedge CLK) vec_r.req && vec_r.vector == eiwk_pkg::VEC_EXT_IRQ && VEC_ACK);
    c_nmi_ack:   cover property (@(posedge CLK) vec_r.req && vec_r.vector == eiwk_pkg::VEC_NMI && VEC_ACK);
    c_level_ext: cover property (@(posedge CLK) !TRIG_CFG.edge_mode && ext_take);
endmodule

/* external_interrupt_wakeup_tb.sv */
// Self-checking bench for the external interrupt and wake-up block.
// Assumes eiwk_core_model stands in for the core.
`timescale 1ns/10ps
module external_interrupt_wakeup_tb;
    logic clk = 0, rst = 1, ext = 0, nmi = 0, en = 0, idl = 0, pdn = 0;
    eiwk_pkg::eiwk_trig_t trig = 2'h3;
    eiwk_pkg::eiwk_vec_t  vreq;
    eiwk_pkg::eiwk_mode_t mode;
    logic ack, wake;
    logic [15:0] lv;
    int hits, h, miscompares = 0, checked = 0;
    // Rows: edge_mode, active_high, enable, vector expected
    logic [3:0] rows [5] = '{4'hF, 4'hB, 4'h7, 4'h3, 4'hC};
    always #2.5 clk = ~clk;
    eiwk_top DUT (.CLK(clk), .RST(rst), .EXT_IRQ_PIN(ext), .NMI_PIN(nmi), .TRIG_CFG(trig), .EXT_IRQ_EN(en),
        .ENTER_IDLE(idl), .ENTER_PDOWN(pdn), .VEC_ACK(ack), .VEC_REQ(vreq), .WAKE(wake), .MODE(mode));
    eiwk_core_model core (.clk(clk), .vec_req(vreq), .vec_ack(ack), .last_vec(lv), .hits(hits));
    task chk_b(string n, logic e, logic g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %0h got %0h", n, e, g);
        end
    endtask
    task chk_v(string n, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %0h got %0h", n, e, g);
        end
    endtask
    task tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wait_wake;
        for (int i = 0; i < 30 && wake !== 1'b1; i++) tick(1);
        chk_b("wake", 1'b1, wake);
    endtask
    initial begin
        #20000;
        miscompares++;
        tally_and_finish;
    end
    initial begin
        tick(16);
        chk_b("req", 1'b0, vreq.req);
        chk_v("mode", {14'h0, eiwk_pkg::EIWK_RUN}, {14'h0, mode});
        rst = 0;
        tick(4);
        foreach (rows[k]) begin
            en = 0;
            trig = rows[k][3:2];
            ext = ~rows[k][2];
            tick(8);
            en = rows[k][1];
            h = hits;
            ext = rows[k][2];
            for (int i = 0; i < 30 && hits == h; i++) tick(1);
            ext = ~rows[k][2];
            tick(12);
            chk_b("hit", rows[k][0], hits != h);
            if (rows[k][0]) chk_v("vec", eiwk_pkg::VEC_EXT_IRQ, lv);
            $display("row %0d done", k);
        end
        // Nonmaskable pulse held beyond one state time while running
        h = hits;
        nmi = 1;
        tick(30);
        nmi = 0;
        tick(10);
        chk_b("nmi hit", 1'b1, hits != h);
        chk_v("vec", eiwk_pkg::VEC_NMI, lv);
        idl = 1;
        tick(1);
        idl = 0;
        tick(2);
        chk_v("mode", {14'h0, eiwk_pkg::EIWK_IDLE}, {14'h0, mode});
        nmi = 1;
        wait_wake;
        tick(30);
        nmi = 0;
        chk_v("vec", eiwk_pkg::VEC_NMI, lv);
        $display("nmi tests done");
        pdn = 1;
        tick(1);
        pdn = 0;
        nmi = 1;
        tick(30);
        nmi = 0;
        chk_v("mode", {14'h0, eiwk_pkg::EIWK_PDOWN}, {14'h0, mode});
        h = hits;
        ext = 1;
        wait_wake;
        tick(10);
        ext = 0;
        chk_b("no ext vec", 1'b0, hits != h);
        chk_v("vec", eiwk_pkg::VEC_NMI, lv);
        en = 1;
        idl = 1;
        tick(1);
        idl = 0;
        ext = 1;
        wait_wake;
        tick(10);
        ext = 0;
        chk_v("vec", eiwk_pkg::VEC_EXT_IRQ, lv);
        $display("wake tests done");
        tally_and_finish;
    end
endmodule
